// ===== test/gate_counter_model.sv
`timescale 1ns/1ps
// Companion counter: advances while the gate is open
module gate_counter_model
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       gate,
	output cmp_pkg::count_t count
);
	import cmp_pkg::*;
	// Rising edge only, so a gate change never races a count
	always_ff @(posedge clk)
	begin
		if (srst)
			count <= '0;
		else if (gate)
			count <= count + 16'h0001;
	end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
`include "cmp_params.svh"
module tb_top;
	import cmp_pkg::*;
	logic   clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic   c1 = 1'b0, c2 = 1'b0, pin = 1'b0;
	logic   [5:0] pins = 6'h2a;
	addr_t  addr = 4'h0;
	byte_t  wdata = 8'h00, rdata;
	logic   hys1, hys2, mm1, mm2, gate;
	count_t cnt, c0;
	int     fail_count = 0, cmp_count = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	cmp_ctrl u_cmp_ctrl
	(
		.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .cmp_one_raw(c1),
		.cmp_two_raw(c2), .external_gate_pin(pin), .port_pins(pins),
		.cmp_one_hysteresis_en(hys1), .cmp_two_hysteresis_en(hys2),
		.cmp_one_mismatch(mm1), .cmp_two_mismatch(mm2),
		.timer_gate(gate)
	);

	gate_counter_model u_gate_counter_model
	(
		.clk(clk), .srst(srst), .gate(gate), .count(cnt)
	);

	// Compare and count
	task automatic check(input byte_t seen, input byte_t exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr_reg(input addr_t a, input byte_t d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input addr_t a, input byte_t exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask

	task automatic t_reset();
		rd_chk(`ADDR_AUX_CONTROL, 8'h02);
		rd_chk(`ADDR_ONE_CONTROL, 8'h00);
		rd_chk(4'hf, 8'h00);
		$display("reset values done");
	endtask

	task automatic t_aux();
		wr_reg(`ADDR_AUX_CONTROL, 8'hff);
		rd_chk(`ADDR_AUX_CONTROL, 8'h1f);
		check({6'h0, hys1, hys2}, 8'h03);
		wr_reg(`ADDR_AUX_CONTROL, 8'h14);
		rd_chk(`ADDR_AUX_CONTROL, 8'h14);
		check({6'h0, hys1, hys2}, 8'h01);
		$display("aux control done");
	endtask

	// Gate pin high 64 cycles, a multiple of every timer clock period
	task automatic pulse_pin();
		@(posedge clk) pin <= 1'b1;
		repeat (64) @(posedge clk);
		pin <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	task automatic t_gate();
		wr_reg(`ADDR_TIMER_CTRL, 8'h03);
		wr_reg(`ADDR_AUX_CONTROL, 8'h02);
		c0 = cnt;
		@(posedge clk) pin <= 1'b1;
		repeat (8) @(posedge clk);
		#1 check({7'h0, gate}, 8'h01);
		repeat (56) @(posedge clk);
		pin <= 1'b0;
		repeat (8) @(posedge clk);
		#1 check({7'h0, gate}, 8'h00);
		check(byte_t'(cnt - c0), 8'h40);
		// Fosc/4 source gives one rise per 8 cycles: 8 counts
		rd_chk(`ADDR_COUNT_LO, 8'h08);
		rd_chk(`ADDR_COUNT_HI, 8'h00);
		// Comparator two as gate source, unsynchronised then synced
		wr_reg(`ADDR_TWO_CONTROL, 8'h80);
		wr_reg(`ADDR_AUX_CONTROL, 8'h00);
		@(posedge clk) c2 <= 1'b1;
		repeat (8) @(posedge clk);
		#1 check({7'h0, gate}, 8'h01);
		@(posedge clk) c2 <= 1'b0;
		wr_reg(`ADDR_AUX_CONTROL, 8'h01);
		repeat (16) @(posedge clk);
		c0 = cnt;
		@(posedge clk) c2 <= 1'b1;
		repeat (20) @(posedge clk);
		#1 check({7'h0, gate}, 8'h01);
		repeat (41) @(posedge clk);
		c2 <= 1'b0;
		repeat (16) @(posedge clk);
		// 61 cycles high, but a synced gate moves only on falls 8 apart
		#1 check(byte_t'((cnt - c0) & 16'h0007), 8'h00);
		check({7'h0, cnt != c0}, 8'h01);
		@(posedge clk) c2 <= 1'b1;
		$display("gate select done");
	endtask

	task automatic t_mirror();
		wr_reg(`ADDR_ONE_CONTROL, 8'h90);
		repeat (8) @(posedge clk);
		rd_chk(`ADDR_ONE_CONTROL, 8'hd0);
		rd_chk(`ADDR_AUX_CONTROL, 8'hc1);
		@(posedge clk) c1 <= 1'b1;
		repeat (8) @(posedge clk);
		#1 check({7'h0, mm1}, 8'h01);
		rd_chk(`ADDR_AUX_CONTROL, 8'h41);
		check({7'h0, mm1}, 8'h01);
		rd_chk(`ADDR_ONE_CONTROL, 8'h90);
		repeat (2) @(posedge clk);
		#1 check({7'h0, mm1}, 8'h00);
		$display("mirror and latch done");
	endtask

	task automatic t_port();
		rd_chk(`ADDR_PORT_A, 8'h00);
		wr_reg(`ADDR_ANALOG_SEL, 8'h00);
		repeat (8) @(posedge clk);
		rd_chk(`ADDR_PORT_A, 8'h2a);
		wr_reg(`ADDR_ANALOG_SEL, 8'h0f);
		rd_chk(`ADDR_PORT_A, 8'h20);
		$display("port read done");
	endtask

	task automatic t_clock();
		wr_reg(`ADDR_TIMER_CTRL, 8'h02);
		wr_reg(`ADDR_AUX_CONTROL, 8'h02);
		wr_reg(`ADDR_COUNT_LO, 8'h00);
		wr_reg(`ADDR_COUNT_HI, 8'h00);
		pulse_pin();
		rd_chk(`ADDR_COUNT_LO, 8'h00);
		// Fosc source gives one rise per 2 cycles: 32 counts
		wr_reg(`ADDR_TIMER_CTRL, 8'h03);
		wr_reg(`ADDR_AUX_CONTROL, 8'h12);
		pulse_pin();
		rd_chk(`ADDR_COUNT_LO, 8'h20);
		// Prescale 1:2 adds 16 more
		wr_reg(`ADDR_TIMER_CTRL, 8'h13);
		pulse_pin();
		rd_chk(`ADDR_COUNT_LO, 8'h30);
		$display("clock source done");
	endtask

	// A reset in mid-run must bring the aux default back
	task automatic t_rerun();
		@(posedge clk) srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd_chk(`ADDR_AUX_CONTROL, 8'h02);
		$display("mid-run reset done");
	endtask

	// Single place where the run ends
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Whole run is about five hundred cycles; cut a hang well beyond that
	initial
	begin
		#100000;
		fail_count++;
		complete_run();
	end

	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_aux();
		t_gate();
		t_mirror();
		t_port();
		t_clock();
		t_rerun();
		complete_run();
	end
endmodule

// ===== verilog/cmp_ctrl.sv
`timescale 1ns/1ps
`include "cmp_params.svh"
module cmp_ctrl
(
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire cmp_pkg::addr_t addr,
	input  wire cmp_pkg::byte_t wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output cmp_pkg::byte_t     rdata,
	input  wire logic          cmp_one_raw,
	input  wire logic          cmp_two_raw,
	input  wire logic          external_gate_pin,
	input  wire logic [5:0]    port_pins,
	output logic               cmp_one_hysteresis_en,
	output logic               cmp_two_hysteresis_en,
	output logic               cmp_one_mismatch,
	output logic               cmp_two_mismatch,
	output logic               timer_gate
);
	import cmp_pkg::*;
	typedef struct packed {
		byte_t  aux;
		byte_t  con_one;
		byte_t  con_two;
		byte_t  analog_sel;
		byte_t  tctrl;
		count_t count;
		logic   seen_one;
		logic   seen_two;
		logic   synced_two;
		logic [2:0] raw_one;
		logic [2:0] raw_two;
		logic [2:0] gate_pin;
		logic [5:0] pins_a;
		logic [5:0] pins_b;
		logic [5:0] pins_c;
		logic   one_now;
		logic   two_now;
		byte_t  rdata;
		logic   gate;
	} ctrl_s;
	ctrl_s st_q;
	ctrl_s st_d;
	logic  out_one;
	logic  out_two;
	logic  sel_two;
	logic  gate_src;
	logic  gate_on;
	tick_if tk ();
	timer_tick_gen u_tick
	(
		.clk       (clk),
		.srst      (srst),
		.alt_clock (st_q.aux[`BIT_ALT_CLOCK]),
		.prescale  (st_q.tctrl[`BIT_T_PRE_LO+1:`BIT_T_PRE_LO]),
		.tk        (tk)
	);
	// Stable level: second and third sync stages agree
	function automatic logic settle(input logic [2:0] s, input logic old);
		settle = (s[1] == s[2]) ? s[2] : old;
	endfunction
	// Control-0 layout with live output bit inserted
	function automatic byte_t con0_view(input byte_t r, input logic o);
		con0_view = r;
		con0_view[`BIT_CON0_OUT] = o;
		con0_view[3] = 1'b0;
	endfunction
	// Polarity-adjusted outputs, forced low while disabled
	assign out_one = st_q.con_one[`BIT_CON0_ON] &
		(st_q.one_now ^ st_q.con_one[`BIT_CON0_POL]);
	assign out_two = st_q.con_two[`BIT_CON0_ON] &
		(st_q.two_now ^ st_q.con_two[`BIT_CON0_POL]);
	assign sel_two = st_q.aux[`BIT_SYNC_EN] ? st_q.synced_two : out_two;
	always_comb
	begin
		st_d = st_q;
		st_d.raw_one = {st_q.raw_one[1:0], cmp_one_raw};
		st_d.raw_two = {st_q.raw_two[1:0], cmp_two_raw};
		st_d.gate_pin = {st_q.gate_pin[1:0], external_gate_pin};
		st_d.pins_a = port_pins;
		st_d.pins_b = st_q.pins_a;
		st_d.pins_c = st_q.pins_b;
		st_d.one_now = settle(st_q.raw_one, st_q.one_now);
		st_d.two_now = settle(st_q.raw_two, st_q.two_now);
		// Capture on the falling edge after the prescaler
		if (tk.fall)
			st_d.synced_two = out_two;
		gate_src = st_q.aux[`BIT_GATE_SELECT] ?
			settle(st_q.gate_pin, st_q.gate) : sel_two;
		st_d.gate = gate_src;
		gate_on = st_q.tctrl[`BIT_T_ON] &
			(~st_q.tctrl[`BIT_T_GATE_EN] | st_q.gate);
		// Count on the rising edge only, never against a fall
		if (tk.rise && gate_on)
			st_d.count = st_q.count + 16'h0001;
		st_d.rdata = 8'h00;
		if (rd)
		begin
			case (addr)
				`ADDR_AUX_CONTROL:
					st_d.rdata = {out_one, out_two, 1'b0,
						st_q.aux[4:0]};
				`ADDR_ONE_CONTROL:
				begin
					st_d.rdata = con0_view(st_q.con_one, out_one);
					st_d.seen_one = out_one;
				end
				`ADDR_TWO_CONTROL:
				begin
					st_d.rdata = con0_view(st_q.con_two, out_two);
					st_d.seen_two = out_two;
				end
				`ADDR_PORT_A:
					st_d.rdata = {2'h0,
						st_q.pins_c & ~st_q.analog_sel[5:0]};
				`ADDR_ANALOG_SEL: st_d.rdata = st_q.analog_sel;
				`ADDR_TIMER_CTRL: st_d.rdata = st_q.tctrl;
				`ADDR_COUNT_LO:   st_d.rdata = st_q.count[7:0];
				`ADDR_COUNT_HI:   st_d.rdata = st_q.count[15:8];
				default:          st_d.rdata = 8'h00;
			endcase
		end
		if (wr)
		begin
			case (addr)
				`ADDR_AUX_CONTROL:
					st_d.aux = wdata & `AUX_WRITE_MASK;
				`ADDR_ONE_CONTROL:
				begin
					st_d.con_one = wdata & `CON0_WRITE_MASK;
					st_d.seen_one = out_one;
				end
				`ADDR_TWO_CONTROL:
				begin
					st_d.con_two = wdata & `CON0_WRITE_MASK;
					st_d.seen_two = out_two;
				end
				`ADDR_ANALOG_SEL: st_d.analog_sel = wdata;
				`ADDR_TIMER_CTRL: st_d.tctrl = wdata;
				`ADDR_COUNT_LO:   st_d.count[7:0] = wdata;
				`ADDR_COUNT_HI:   st_d.count[15:8] = wdata;
				default:          st_d.count = st_d.count;
			endcase
		end
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q <= '0;
			st_q.aux <= `AUX_RESET;
			st_q.analog_sel <= `ANALOG_SEL_RESET;
		end
		else
			st_q <= st_d;
	end
	assign rdata = st_q.rdata;
	assign cmp_one_hysteresis_en = st_q.aux[`BIT_HYS_ONE];
	assign cmp_two_hysteresis_en = st_q.aux[`BIT_HYS_TWO];
	assign cmp_one_mismatch = out_one ^ st_q.seen_one;
	assign cmp_two_mismatch = out_two ^ st_q.seen_two;
	assign timer_gate = st_q.gate;
	// Checks
	a_aux_reset_value: assert property (@(posedge clk)
		$fell(srst) |-> st_q.aux == `AUX_RESET)
		else $error("aux reset value wrong");
	a_port_analog_zero: assert property (@(posedge clk)
		disable iff (srst) rd && addr == `ADDR_PORT_A
		|=> (rdata[5:0] & st_q.analog_sel[5:0]) == 6'h00)
		else $error("analog pin read non-zero");
	a_mirror_read_same: assert property (@(posedge clk)
		disable iff (srst) rd && addr == `ADDR_AUX_CONTROL
		|=> rdata[7:6] == $past({out_one, out_two}))
		else $error("mirror bits wrong");
	a_mirror_no_touch: assert property (@(posedge clk)
		disable iff (srst) rd && addr == `ADDR_AUX_CONTROL && !wr
		|=> $stable({st_q.seen_one, st_q.seen_two}))
		else $error("mirror read moved latch");
	a_unused_bit_zero: assert property (@(posedge clk)
		disable iff (srst) st_q.aux[5] == 1'b0)
		else $error("aux bit 5 set");
	a_read_loads_latch: assert property (@(posedge clk)
		disable iff (srst) rd && addr == `ADDR_ONE_CONTROL
		|=> st_q.seen_one == $past(out_one))
		else $error("latch not loaded");
	a_count_needs_on: assert property (@(posedge clk)
		disable iff (srst) !st_q.tctrl[`BIT_T_ON] && !wr
		|=> $stable(st_q.count))
		else $error("count while off");
	a_count_on_rise: assert property (@(posedge clk)
		disable iff (srst) !wr && st_q.count != st_d.count |-> tk.rise)
		else $error("count off rise");
	a_hys_follows_bit: assert property (@(posedge clk)
		disable iff (srst) wr && addr == `ADDR_AUX_CONTROL
		|=> cmp_two_hysteresis_en == $past(wdata[2]))
		else $error("hysteresis enable wrong");
	// Gate must follow the selected source one cycle later
	a_gate_pin_route: assert property (@(posedge clk)
		disable iff (srst)
		st_q.aux[`BIT_GATE_SELECT] && st_q.gate_pin[2:1] == 2'b11
		|=> timer_gate)
		else $error("pin gate not routed");
	a_gate_cmp_route: assert property (@(posedge clk)
		disable iff (srst) !st_q.aux[`BIT_GATE_SELECT]
		|=> timer_gate == $past(sel_two))
		else $error("comparator gate not routed");
	// Synced copy may only move on a prescaled falling edge
	a_sync_on_fall: assert property (@(posedge clk)
		disable iff (srst) !tk.fall |=> $stable(st_q.synced_two))
		else $error("sync copy moved off a fall");
	a_count_gate_shut: assert property (@(posedge clk)
		disable iff (srst)
		st_q.tctrl[`BIT_T_GATE_EN] && !st_q.gate && !wr
		|=> $stable(st_q.count))
		else $error("count with gate shut");
	c_gate_comparator: cover property (@(posedge clk)
		!st_q.aux[`BIT_GATE_SELECT] && tk.rise && gate_on);
	c_sync_capture: cover property (@(posedge clk)
		st_q.aux[`BIT_SYNC_EN] && tk.fall && out_two);
	c_mismatch: cover property (@(posedge clk) cmp_one_mismatch);
	c_gate_pin: cover property (@(posedge clk)
		st_q.aux[`BIT_GATE_SELECT] && tk.rise && gate_on);
	c_alt_clock: cover property (@(posedge clk)
		st_q.aux[`BIT_ALT_CLOCK] && tk.rise && gate_on);
endmodule

// ===== verilog/cmp_params.svh
// Functional notes
// - Analog-configured port pins read as zero
// - Gate select 1 picks pin, 0 comparator
// - Timer counts only when on and, with gate enable set, gate open
// - Sync bit latches comparator on falling edge
// - Sync latch clocked after the prescaler
// - Counter advances on rising timer clock edge
// - Mirror bits show both outputs, same read
// - Mirror read leaves mismatch latches alone
// - Alt clock bit picks fosc or fosc/4
// - Hysteresis enables per comparator, bits 3/2
// - Aux control resets to 00-0 0010
// - Aux bit 5 reads zero, ignores writes
// - Control-0 read loads mismatch latch
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH
`define ADDR_AUX_CONTROL     4'h0
`define ADDR_ONE_CONTROL     4'h1
`define ADDR_TWO_CONTROL     4'h2
`define ADDR_PORT_A          4'h3
`define ADDR_ANALOG_SEL      4'h4
`define ADDR_TIMER_CTRL      4'h5
`define ADDR_COUNT_LO        4'h6
`define ADDR_COUNT_HI        4'h7
`define AUX_RESET            8'h02
`define AUX_WRITE_MASK       8'h1f
`define CON0_RESET           8'h00
`define CON0_WRITE_MASK      8'hb7
`define ANALOG_SEL_RESET     8'hff
`define TCTRL_RESET          8'h00
`define BIT_MIRROR_ONE       7
`define BIT_MIRROR_TWO       6
`define BIT_ALT_CLOCK        4
`define BIT_HYS_ONE          3
`define BIT_HYS_TWO          2
`define BIT_GATE_SELECT      1
`define BIT_SYNC_EN          0
`define BIT_CON0_ON          7
`define BIT_CON0_OUT         6
`define BIT_CON0_POL         4
`define BIT_T_ON             0
`define BIT_T_GATE_EN        1
`define BIT_T_PRE_LO         4
`define QUARTER_DIV          2'h3
`endif

// ===== verilog/cmp_pkg.sv
package cmp_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [3:0]  addr_t;
	typedef logic [15:0] count_t;
endpackage

// ===== verilog/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
	logic tick;
	logic rise;
	logic fall;
	modport src (output tick, output rise, output fall);
	modport dst (input tick, input rise, input fall);
endinterface

// ===== verilog/timer_tick_gen.sv
`timescale 1ns/1ps
`include "cmp_params.svh"
// Builds the timer clock as a level plus edge pulses on clk
module timer_tick_gen
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic alt_clock,
	input  wire logic [1:0] prescale,
	tick_if.src       tk
);
	import cmp_pkg::*;
	typedef struct packed {
		logic [1:0] quarter;
		logic [7:0] pre;
		logic       level;
	} tick_s;
	tick_s st_q;
	tick_s st_d;
	logic  src_en;
	logic  lvl_n;
	// Base source: fosc every cycle, or fosc/4
	always_comb
	begin
		st_d = st_q;
		st_d.quarter = st_q.quarter + 2'h1;
		src_en = alt_clock | (st_q.quarter == `QUARTER_DIV);
		if (src_en)
			st_d.pre = st_q.pre + 8'h01;
		lvl_n = st_q.level;
		// Prescaled level from a divider bit; each step halves the rate
		case (prescale)
			2'h0: lvl_n = src_en ? ~st_q.level : st_q.level;
			2'h1: lvl_n = st_d.pre[1];
			2'h2: lvl_n = st_d.pre[2];
			default: lvl_n = st_d.pre[3];
		endcase
		st_d.level = lvl_n;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	// Edges after the prescaler, so the sync latch sees the same clock
	assign tk.tick = st_q.level;
	assign tk.rise = st_d.level & ~st_q.level;
	assign tk.fall = ~st_d.level & st_q.level;
endmodule
